// [src/rmpg_defs.svh]
// Register map, field positions, reset values and timing constants for the rail mode and power-good block
// Notes on behaviour
// RL1 - Bits 5, 4 and 3 of the converter register pick the mode of converters three, two and one: 0 is automatic, 1 is forced PWM, all resetting to 0.
// RL2 - Bit 2 of the converter register resets to 1, and while it is 0 converter three stays off whatever the control pins ask.
// RL3 - Bit 1 of the converter register resets to 1, and while it is 0 converter two stays off whatever the control pins ask.
// RL4 - Bit 0 of the converter register resets to 1, and while it is 0 converter one stays off whatever the control pins ask.
// RL5 - Each power-good delay starts when all rails grouped to the pin are in regulation, and power good asserts when it ends.
// RL6 - Bits 7-5 of the delay register set output two's delay, reset 1, codes 0 to 7 giving 0, 5, 10, 15, 20, 50, 75 and 100 ms.
// RL7 - Bits 4-2 of the delay register set output four's delay, reset 0, with the same eight-step code.
// RL8 - Bits 1-0 of the delay register set output one's delay, reset 1, codes 0 to 3 giving 0, 5, 10 and 15 ms.
// RL9 - Any delay may differ from nominal by up to ten percent either way, and tests accept that.
// RL10 - Each output may act as power good, level shifter or bus-driven output, with the delay only on the first two.
// RL11 - A bus enable override forces its converter on only while the disable bit is not 0.
// RL12 - A cycle counter times each delay, restarts whenever a grouped rail drops, and holds the pin low until done.
`ifndef RMPG_DEFS_SVH
`define RMPG_DEFS_SVH
`define RMPG_OFS_CONV 8'h9c
`define RMPG_OFS_PGD 8'h9d
`define RMPG_RST_CONV 8'h07
`define RMPG_RST_PGD 8'h21
`define RMPG_RD_UNMAPPED 8'h00
`define RMPG_CONV_MODE_LSB 3
`define RMPG_CONV_MODE_MSB 5
`define RMPG_CONV_DIS_LSB 0
`define RMPG_CONV_DIS_MSB 2
`define RMPG_PGD_TWO_LSB 5
`define RMPG_PGD_TWO_MSB 7
`define RMPG_PGD_FOUR_LSB 2
`define RMPG_PGD_FOUR_MSB 4
`define RMPG_PGD_ONE_LSB 0
`define RMPG_PGD_ONE_MSB 1
`define RMPG_CLK_PERIOD_NS 25
`define RMPG_MS_NS 1000000
`define RMPG_CYCLES_PER_MS (`RMPG_MS_NS / `RMPG_CLK_PERIOD_NS)
`define RMPG_DLY_C0_MS 7'h00
`define RMPG_DLY_C1_MS 7'h05
`define RMPG_DLY_C2_MS 7'h0a
`define RMPG_DLY_C3_MS 7'h0f
`define RMPG_DLY_C4_MS 7'h14
`define RMPG_DLY_C5_MS 7'h32
`define RMPG_DLY_C6_MS 7'h4b
`define RMPG_DLY_C7_MS 7'h64
`endif

// [src/rmpg_pkg.sv]
// Types shared by the rail mode and power-good block
`default_nettype none
package rmpg_pkg;
	typedef enum logic [2:0] {
		RMPG_WAIT = 3'h1,
		RMPG_COUNT = 3'h2,
		RMPG_GOOD = 3'h4
	} rmpg_state_type;
	typedef enum logic [1:0] {
		RMPG_FN_PGOOD = 2'h0,
		RMPG_FN_SHIFT = 2'h1,
		RMPG_FN_GPO = 2'h2
	} rmpg_func_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rmpg_reg_req_type;
endpackage : rmpg_pkg
`default_nettype wire

// [src/rmpg_top.sv]
// Converter mode and disable register, power-good delay register and delayed output channels
`include "rmpg_defs.svh"
`default_nettype none
module rmpg_channel #(
	parameter int CYCLES_PER_MS = `RMPG_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Configuration
	input wire logic [6:0] i_delay_ms,
	input wire rmpg_pkg::rmpg_func_type i_func,
	// Sources
	input wire logic i_rails_good,
	input wire logic i_shift_level,
	input wire logic i_gpo_level,
	// Pin
	output logic o_pin
);
	rmpg_pkg::rmpg_state_type state;
	rmpg_pkg::rmpg_state_type next_state;
	logic [23:0] cnt;
	logic [23:0] next_cnt;
	logic next_pin;
	wire logic [23:0] target = 24'(int'(i_delay_ms) * CYCLES_PER_MS);
	wire logic is_gpo = (i_func == rmpg_pkg::RMPG_FN_GPO);
	wire logic src = (i_func == rmpg_pkg::RMPG_FN_SHIFT) ? i_shift_level : i_rails_good;
	wire logic zero_delay = (target == 24'h000000);
	wire logic at_target = (cnt >= target);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			rmpg_pkg::RMPG_WAIT: begin
				next_cnt = 24'h000000;
				if (src) begin
					next_state = zero_delay ? rmpg_pkg::RMPG_GOOD : rmpg_pkg::RMPG_COUNT; // RL5
					next_cnt = 24'h000001;
					if (zero_delay) begin
						next_cnt = 24'h000000;
					end
				end
			end
			rmpg_pkg::RMPG_COUNT: begin
				if (!src) begin
					next_state = rmpg_pkg::RMPG_WAIT; // RL12
					next_cnt = 24'h000000;
				end else if (at_target) begin
					next_state = rmpg_pkg::RMPG_GOOD; // RL5
				end else begin
					next_cnt = cnt + 24'h000001; // RL12
				end
			end
			rmpg_pkg::RMPG_GOOD: begin
				if (!src) begin
					next_state = rmpg_pkg::RMPG_WAIT; // RL12
					next_cnt = 24'h000000;
				end
			end
			default: begin
				next_state = rmpg_pkg::RMPG_WAIT;
				next_cnt = 24'h000000;
			end
		endcase
	end

	assign next_pin = is_gpo ? i_gpo_level : (next_state == rmpg_pkg::RMPG_GOOD); // RL10

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= rmpg_pkg::RMPG_WAIT;
			cnt <= 24'h000000;
			o_pin <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			o_pin <= next_pin;
		end
	end

	// Delay channel checks
	AST_PG_LOW_WHILE_COUNTING: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL12
		(state == rmpg_pkg::RMPG_COUNT) && !is_gpo && $stable(i_func) |-> !o_pin)
		else $error("Power good high while delay still counting");
	AST_PG_DROPS_WITH_RAIL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL12
		!is_gpo && !src |=> !o_pin)
		else $error("Power good stayed high after grouped rail dropped");
	AST_PG_ZERO_DELAY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL5
		(state == rmpg_pkg::RMPG_WAIT) && src && !is_gpo && (target == 24'h000000) |=> o_pin)
		else $error("Zero delay did not assert power good at once");
	AST_PG_RISE_AT_TARGET: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL9
		$rose(o_pin) && !is_gpo && $stable(i_func) |-> (cnt == target))
		else $error("Power good rose off the programmed delay");
	AST_GPO_FOLLOWS_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL10
		is_gpo |=> (o_pin == $past(i_gpo_level)))
		else $error("Bus-driven output does not follow its level");
	COV_PG_DELAYED_RISE: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state == rmpg_pkg::RMPG_COUNT) ##1 (state == rmpg_pkg::RMPG_GOOD));
	COV_PG_RESTART: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(state == rmpg_pkg::RMPG_COUNT) ##1 (state == rmpg_pkg::RMPG_WAIT));

	AST_PG_LOW_IN_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL5
		(state == rmpg_pkg::RMPG_WAIT) && !is_gpo && $stable(i_func) |-> !o_pin)
		else $error("Power good high before its rails were in regulation");
	AST_PG_HOLDS_WHILE_GOOD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL5
		(state == rmpg_pkg::RMPG_GOOD) && src && !is_gpo |=> o_pin)
		else $error("Power good fell while its rails stayed in regulation");
	AST_CNT_WITHIN_TARGET: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL12
		(state == rmpg_pkg::RMPG_COUNT) && $stable(i_delay_ms) |-> (cnt <= target))
		else $error("Delay counter ran past its target");
	AST_CNT_STEPS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL12
		(state == rmpg_pkg::RMPG_COUNT) && src && !at_target |=> (cnt == $past(cnt) + 24'h000001))
		else $error("Delay counter did not advance by one");
	AST_CNT_RESTARTS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL12
		(state == rmpg_pkg::RMPG_COUNT) && !src |=> (state == rmpg_pkg::RMPG_WAIT) && (cnt == 24'h000000))
		else $error("Delay counter did not restart when a rail dropped");
	COV_SHIFT_RISE: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		(i_func == rmpg_pkg::RMPG_FN_SHIFT) && $rose(o_pin));
endmodule : rmpg_channel

module rmpg_top #(
	parameter int CYCLES_PER_MS = `RMPG_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Register port from the serial control engine
	input wire rmpg_pkg::rmpg_reg_req_type i_reg_req,
	output logic [7:0] o_reg_rdata,
	// Converter control: index 0 is converter one
	input wire logic [2:0] i_ctl_request,
	input wire logic [2:0] i_bus_enable_override,
	output logic [2:0] o_conv_enable,
	output logic [2:0] o_conv_mode_select,
	// Output pins: index 0 is output one, 1 output two, 2 output four
	input wire rmpg_pkg::rmpg_func_type i_out_func [3],
	input wire logic [2:0] i_rails_good,
	input wire logic [2:0] i_shift_level,
	input wire logic [2:0] i_gpo_level,
	output logic [2:0] o_general_output
);
	logic [7:0] conv_reg;
	logic [7:0] pgd_reg;
	logic [7:0] next_rdata;
	logic [2:0] next_enable;
	logic [6:0] dly_ms [3];

	function automatic logic [6:0] ms_of_code(input logic [2:0] code);
		case (code)
			3'h0: ms_of_code = `RMPG_DLY_C0_MS;
			3'h1: ms_of_code = `RMPG_DLY_C1_MS;
			3'h2: ms_of_code = `RMPG_DLY_C2_MS;
			3'h3: ms_of_code = `RMPG_DLY_C3_MS;
			3'h4: ms_of_code = `RMPG_DLY_C4_MS;
			3'h5: ms_of_code = `RMPG_DLY_C5_MS;
			3'h6: ms_of_code = `RMPG_DLY_C6_MS;
			default: ms_of_code = `RMPG_DLY_C7_MS;
		endcase
	endfunction : ms_of_code

	wire logic hit_conv = (i_reg_req.addr == `RMPG_OFS_CONV);
	wire logic hit_pgd = (i_reg_req.addr == `RMPG_OFS_PGD);
	wire logic wr_conv = i_reg_req.wr && hit_conv;
	wire logic wr_pgd = i_reg_req.wr && hit_pgd;
	// Named register fields
	wire logic conv_one_mode_select = conv_reg[`RMPG_CONV_MODE_LSB];
	wire logic conv_two_mode_select = conv_reg[`RMPG_CONV_MODE_LSB + 1];
	wire logic conv_three_mode_select = conv_reg[`RMPG_CONV_MODE_MSB];
	wire logic conv_one_soft_disable = conv_reg[`RMPG_CONV_DIS_LSB];
	wire logic conv_two_soft_disable = conv_reg[`RMPG_CONV_DIS_LSB + 1];
	wire logic conv_three_soft_disable = conv_reg[`RMPG_CONV_DIS_MSB];
	wire logic [2:0] soft_dis = {conv_three_soft_disable, conv_two_soft_disable, conv_one_soft_disable};
	wire logic [2:0] mode_sel = {conv_three_mode_select, conv_two_mode_select, conv_one_mode_select};
	wire logic [1:0] out_one_good_delay = pgd_reg[`RMPG_PGD_ONE_MSB:`RMPG_PGD_ONE_LSB];
	wire logic [2:0] out_two_good_delay = pgd_reg[`RMPG_PGD_TWO_MSB:`RMPG_PGD_TWO_LSB];
	wire logic [2:0] out_four_good_delay = pgd_reg[`RMPG_PGD_FOUR_MSB:`RMPG_PGD_FOUR_LSB];

	assign next_rdata = hit_conv ? conv_reg : (hit_pgd ? pgd_reg : `RMPG_RD_UNMAPPED);
	assign next_enable = soft_dis & (i_ctl_request | i_bus_enable_override); // RL2 RL3 RL4 RL11
	assign dly_ms[0] = ms_of_code({1'b0, out_one_good_delay}); // RL8
	assign dly_ms[1] = ms_of_code(out_two_good_delay); // RL6
	assign dly_ms[2] = ms_of_code(out_four_good_delay); // RL7

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			conv_reg <= `RMPG_RST_CONV; // RL1 RL2 RL3 RL4
			pgd_reg <= `RMPG_RST_PGD; // RL6 RL7 RL8
		end else begin
			if (wr_conv) begin
				conv_reg <= i_reg_req.wdata;
			end
			if (wr_pgd) begin
				pgd_reg <= i_reg_req.wdata;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 8'h00;
			o_conv_enable <= 3'h0;
			o_conv_mode_select <= 3'h0;
		end else begin
			if (i_reg_req.rd) begin
				o_reg_rdata <= next_rdata;
			end
			o_conv_enable <= next_enable;
			o_conv_mode_select <= mode_sel; // RL1
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_out
			rmpg_channel #(
				.CYCLES_PER_MS(CYCLES_PER_MS)
			) u_channel (
				.i_sys_clk(i_sys_clk),
				.i_reset_n(i_reset_n),
				.i_delay_ms(dly_ms[g]),
				.i_func(i_out_func[g]),
				.i_rails_good(i_rails_good[g]),
				.i_shift_level(i_shift_level[g]),
				.i_gpo_level(i_gpo_level[g]),
				.o_pin(o_general_output[g])
			);
		end
	endgenerate

	// Register port checks
	AST_MODE_FOLLOWS_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL1
		wr_conv ##1 1'b1 |=> (o_conv_mode_select == $past(i_reg_req.wdata[5:3], 2)))
		else $error("Mode outputs do not follow the written bits");
	AST_CONV_THREE_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL2
		!conv_reg[2] |=> !o_conv_enable[2])
		else $error("Converter three on while disabled");
	AST_CONV_TWO_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL3
		!conv_reg[1] |=> !o_conv_enable[1])
		else $error("Converter two on while disabled");
	AST_CONV_ONE_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL4
		!conv_reg[0] |=> !o_conv_enable[0])
		else $error("Converter one on while disabled");
	AST_OVERRIDE_FORCES_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL11
		(conv_reg[0] && i_bus_enable_override[0]) |=> o_conv_enable[0])
		else $error("Override did not force converter one on");
	AST_DELAY_READBACK: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL6
		wr_pgd ##1 !i_reg_req.wr ##1 (i_reg_req.rd && hit_pgd && !i_reg_req.wr)
		|=> (o_reg_rdata == $past(i_reg_req.wdata, 3)))
		else $error("Delay register readback differs from write");
	AST_UNMAPPED_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_reg_req.rd && !hit_conv && !hit_pgd |=> (o_reg_rdata == 8'h00))
		else $error("Unmapped read did not return zero");
	AST_RDATA_HOLDS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!i_reg_req.rd |=> $stable(o_reg_rdata))
		else $error("Read data changed without a read");
	AST_FOREIGN_WRITE_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_reg_req.wr && !hit_conv && !hit_pgd |=> $stable(conv_reg) && $stable(pgd_reg))
		else $error("Write to another address changed a register");
	AST_MODE_TRACKS_REG: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL1
		1'b1 |=> (o_conv_mode_select == $past(mode_sel)))
		else $error("Mode outputs lag the register");

	// Converter enable checks
	AST_CONV_ONE_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL4
		conv_one_soft_disable && i_ctl_request[0] |=> o_conv_enable[0])
		else $error("Converter one off although requested and allowed");
	AST_CONV_TWO_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL3
		conv_two_soft_disable && i_ctl_request[1] |=> o_conv_enable[1])
		else $error("Converter two off although requested and allowed");
	AST_CONV_THREE_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL2
		conv_three_soft_disable && i_ctl_request[2] |=> o_conv_enable[2])
		else $error("Converter three off although requested and allowed");
	AST_CONV_ONE_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL4
		!i_ctl_request[0] && !i_bus_enable_override[0] |=> !o_conv_enable[0])
		else $error("Converter one on without a request");
	AST_CONV_TWO_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL3
		!i_ctl_request[1] && !i_bus_enable_override[1] |=> !o_conv_enable[1])
		else $error("Converter two on without a request");
	AST_CONV_THREE_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL2
		!i_ctl_request[2] && !i_bus_enable_override[2] |=> !o_conv_enable[2])
		else $error("Converter three on without a request");
	AST_OVERRIDE_TWO_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL11
		conv_two_soft_disable && i_bus_enable_override[1] |=> o_conv_enable[1])
		else $error("Override did not force converter two on");
	AST_OVERRIDE_THREE_ON: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL11
		conv_three_soft_disable && i_bus_enable_override[2] |=> o_conv_enable[2])
		else $error("Override did not force converter three on");

	// Delay code checks
	AST_OUT_ONE_CODE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL8
		(out_one_good_delay == 2'h3) |-> (dly_ms[0] == `RMPG_DLY_C3_MS))
		else $error("Output one delay code three not decoded to its top step");
	AST_OUT_TWO_CODE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL6
		(out_two_good_delay == 3'h7) |-> (dly_ms[1] == `RMPG_DLY_C7_MS))
		else $error("Output two delay code seven not decoded to its top step");
	AST_OUT_FOUR_CODE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL7
		(out_four_good_delay == 3'h5) |-> (dly_ms[2] == `RMPG_DLY_C5_MS))
		else $error("Output four delay code five not decoded to its step");
	COV_OVERRIDE_BLOCKED: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!conv_reg[1] && i_bus_enable_override[1]);
	COV_ALL_GOOD: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_general_output == 3'h7);
endmodule : rmpg_top
`default_nettype wire

// [bench/rmpg_host.sv]
// Register-port master standing in for the serial control engine
`default_nettype none
module rmpg_host (
	// Clock
	input wire logic i_sys_clk,
	// Register port
	input wire logic [7:0] i_reg_rdata,
	output logic o_unused,
	output var rmpg_pkg::rmpg_reg_req_type o_reg_req
);
	timeunit 1ns;
	timeprecision 100ps;
	assign o_unused = 1'b0;
	initial o_reg_req = '0;
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		o_reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge i_sys_clk);
		o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
		@(posedge i_sys_clk);
	endtask : write_reg
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		o_reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge i_sys_clk);
		o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
		@(posedge i_sys_clk);
		data = i_reg_rdata;
	endtask : read_reg
endmodule : rmpg_host
`default_nettype wire

// [bench/tb.sv]
// Self-checking testbench for the rail mode and power-good block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CPM = 4;
	logic i_sys_clk = 1'b0;
	logic i_reset_n = 1'b0;
	rmpg_pkg::rmpg_reg_req_type reg_req;
	logic [7:0] rdata;
	logic [2:0] ctl = 3'h7, ovr = 3'h0, conv_en, mode, gout;
	logic [2:0] rails = 3'h0, shift = 3'h0, gpo = 3'h0;
	rmpg_pkg::rmpg_func_type func [3] = '{rmpg_pkg::RMPG_FN_PGOOD, rmpg_pkg::RMPG_FN_PGOOD, rmpg_pkg::RMPG_FN_PGOOD};
	int bad_count = 0;
	int checked = 0;
	int first [3];
	int ms [8] = '{0, 5, 10, 15, 20, 50, 75, 100};
	always #12.5 i_sys_clk = ~i_sys_clk;
	rmpg_host host_u (.i_sys_clk(i_sys_clk), .i_reg_rdata(rdata), .o_unused(), .o_reg_req(reg_req));
	rmpg_top #(.CYCLES_PER_MS(CPM)) dut_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_req(reg_req),
		.o_reg_rdata(rdata), .i_ctl_request(ctl), .i_bus_enable_override(ovr), .o_conv_enable(conv_en),
		.o_conv_mode_select(mode), .i_out_func(func), .i_rails_good(rails), .i_shift_level(shift),
		.i_gpo_level(gpo), .o_general_output(gout));
	task automatic finish_test();
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
		logic [7:0] d;
		host_u.read_reg(addr, d);
		check(d, exp, what);
	endtask : rd_check
	task automatic edges(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask : edges
	// Records the first cycle each pin is seen high
	task automatic run_until(input int limit);
		first = '{-1, -1, -1};
		for (int c = 0; c < limit; c++) begin
			@(posedge i_sys_clk);
			for (int p = 0; p < 3; p++) if (first[p] < 0 && gout[p] === 1'b1) first[p] = c;
		end
		if (first[0] < 0 || first[1] < 0 || first[2] < 0) begin
			bad_count++;
			$display("mismatch at %0t: pin never rose", $time);
			finish_test();
		end
	endtask : run_until
	task automatic check_delay(input int p, input int nom_ms);
		int nom;
		nom = nom_ms * CPM;
		check({7'h0, (first[p] * 10 >= nom * 9) && (first[p] * 10 <= nom * 11 + 30)}, 8'h01, "delay");
	endtask : check_delay
	task automatic test_reset();
		host_u.write_reg(8'h9e, 8'hff);
		rd_check(8'h9c, 8'h07, "conv reset");
		rd_check(8'h9d, 8'h21, "delay reset");
		rd_check(8'h9e, 8'h00, "unmapped read");
		check({5'h0, mode}, 8'h00, "mode reset");
		check({5'h0, conv_en}, 8'h07, "enable after reset");
	endtask : test_reset
	task automatic test_conv();
		host_u.write_reg(8'h9c, 8'h38);
		edges(2);
		check({5'h0, mode}, 8'h07, "forced pwm");
		check({5'h0, conv_en}, 8'h00, "disabled");
		ovr <= 3'h7;
		edges(3);
		check({5'h0, conv_en}, 8'h00, "override masked");
		host_u.write_reg(8'h9c, 8'h15);
		edges(2);
		check({5'h0, mode}, 8'h02, "mode two");
		check({5'h0, conv_en}, 8'h05, "two off");
		host_u.write_reg(8'h9c, 8'h0e);
		ctl <= 3'h0;
		edges(2);
		check({5'h0, conv_en}, 8'h06, "override on, one off");
		ovr <= 3'h0;
		edges(2);
		check({5'h0, conv_en}, 8'h00, "no request");
		rd_check(8'h9c, 8'h0e, "conv readback");
	endtask : test_conv
	task automatic test_codes();
		for (int k = 0; k < 8; k++) begin
			host_u.write_reg(8'h9d, {3'(k), 3'(7 - k), 2'(k)});
			rd_check(8'h9d, {3'(k), 3'(7 - k), 2'(k)}, "delay readback");
			rails <= 3'h7;
			run_until(460);
			check_delay(0, ms[k % 4]);
			check_delay(1, ms[k]);
			check_delay(2, ms[7 - k]);
			rails <= 3'h0;
			edges(3);
			check({5'h0, gout}, 8'h00, "rails lost");
		end
	endtask : test_codes
	task automatic test_restart_modes();
		host_u.write_reg(8'h9d, 8'he0);
		rails <= 3'h7;
		edges(200);
		check({7'h0, gout[1]}, 8'h00, "held during count");
		rails <= 3'h0;
		edges(1);
		rails <= 3'h7;
		run_until(460);
		check_delay(1, 100);
		rails <= 3'h5;
		func[1] <= rmpg_pkg::RMPG_FN_SHIFT;
		edges(3);
		check({7'h0, gout[1]}, 8'h00, "shifter source low");
		shift <= 3'h2;
		run_until(460);
		check_delay(1, 100);
		func[1] <= rmpg_pkg::RMPG_FN_GPO;
		shift <= 3'h0;
		gpo <= 3'h0;
		edges(3);
		check({7'h0, gout[1]}, 8'h00, "gpo low");
		gpo <= 3'h2;
		edges(3);
		check({7'h0, gout[1]}, 8'h01, "gpo high");
	endtask : test_restart_modes
	initial begin
		edges(16);
		i_reset_n <= 1'b1;
		edges(2);
		test_reset();
		test_conv();
		test_codes();
		test_restart_modes();
		finish_test();
	end
endmodule : tb
`default_nettype wire
